// *** hw/cftcd_defines.vh ***
// Purpose: constants of the cache control and fault-tolerance block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef CFTCD_DEFINES_VH
`define CFTCD_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define CFTCD_OFF_CTRL 4'h0
`define CFTCD_OFF_DASI 4'h4
`define CFTCD_OFF_CENA 4'h8
// ****************************************
// control word fields
// ****************************************
`define CFTCD_RF_READOUT 29
`define CFTCD_PAR_SEL 28
`define CFTCD_XPAT_HI 27
`define CFTCD_XPAT_LO 24
`define CFTCD_SNOOP 23
`define CFTCD_DFLUSH 22
`define CFTCD_IFLUSH 21
`define CFTCD_SCHEME_HI 20
`define CFTCD_SCHEME_LO 19
`define CFTCD_BURST 16
`define CFTCD_IPEND 15
`define CFTCD_DPEND 14
`define CFTCD_ITAG_CNT_LO 12
`define CFTCD_IWORD_CNT_LO 10
`define CFTCD_DTAG_CNT_LO 8
`define CFTCD_DWORD_CNT_LO 6
`define CFTCD_DFREEZE 5
`define CFTCD_IFREEZE 4
`define CFTCD_DSTATE_LO 2
`define CFTCD_ISTATE_LO 0
// ****************************************
// enable register fields
// ****************************************
`define CFTCD_EN_I 0
`define CFTCD_EN_D 1
`define CFTCD_THAW_I 2
`define CFTCD_THAW_D 3
// ****************************************
// codes and reset values
// ****************************************
`define CFTCD_SCHEME_NONE 2'h0
`define CFTCD_SCHEME_4BIT 2'h1
`define CFTCD_ST_OFF 2'h0
`define CFTCD_ST_FROZEN 2'h1
`define CFTCD_ST_ON 2'h3
`define CFTCD_CNT_MAX 2'h3
`define CFTCD_ASI_ITAG 4'hC
`define CFTCD_ASI_IWORD 4'hD
`define CFTCD_ASI_DTAG 4'hE
`define CFTCD_ASI_DWORD 4'hF
`define CFTCD_WIN_BASE 3'h7
`define CFTCD_CTX_LO 16
`define CFTCD_RST_CTRL 32'h00000000
`define CFTCD_RST_ASI 4'h0
`define CFTCD_RST_CENA 2'h0
`endif

// *** hw/cftcd_chkgen.v ***
// Purpose: four check bits, one parity bit per byte of a word
// Assumes: combinational, used by the control block
// Notes: odd bytes and even bytes alike, no inversion
`timescale 1ns/10ps
module cftcd_chkgen (
	// word in
	input wire [31:0] word_in,
	// check bits out
	output wire [3:0] chk_out
);
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_byte
			assign chk_out[b] = ^word_in[8*b+7:8*b];
		end
	endgenerate
endmodule

// *** hw/cftcd_ctrl.v ***
// Purpose: cache control word, flush walkers, error counters, diagnostic path
// Assumes: one 50 MHz clock, synchronous active-high reset, arrays answer one cycle after a select
// Notes: diagnostic read data stand two cycles after the request
`timescale 1ns/10ps
`include "cftcd_defines.vh"

// What this block does
// (RQ1) readout flag lets space 0xF read regfile bits
// (RQ2) parity select returns check bits, else word
// (RQ3) diagnostic write xors check bits with pattern
// (RQ4) snoop enable bit drives data cache snooping
// (RQ5) data flush bit starts flush, reads zero
// (RQ6) instruction flush bit starts flush, reads zero
// (RQ7) scheme field reports 00 or 01
// (RQ8) burst fetch bit enables burst line fills
// (RQ9) instruction flush pending while flush runs
// (RQ10) data flush pending while flush runs
// (RQ11) four two-bit parity error counters
// (RQ12) data cache freezes on taken interrupt
// (RQ13) instruction cache freezes on taken interrupt
// (RQ14) data state: x0 off, 01 frozen, 11 on
// (RQ15) instruction state uses same encoding
// (RQ16) parity select turns spaces c-f to check readout
// (RQ17) tag read: context 23:16, check 3:0
// (RQ18) check bits generated on every line fill
// (RQ19) debug window uses held space and addr 19:0
// (RQ20) check error flushes line and restarts instruction
// (RQ21) counters saturate at three, software clears
// (RQ22) flush walks all lines, pending clears after last
// (RQ23) counter writes load, status fields ignore writes
module cftcd_ctrl #(
	parameter IDX_W = 7,
	parameter LINES = 128,
	parameter PROT_SCHEME = `CFTCD_SCHEME_4BIT
) (
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// register port
	input wire [3:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	// pipeline events
	input wire irq_taken_in,
	input wire err_itag_in,
	input wire err_iword_in,
	input wire err_dtag_in,
	input wire err_dword_in,
	input wire [IDX_W-1:0] err_index_in,
	// line fill
	input wire fill_in,
	input wire [31:0] fill_data_in,
	output reg [3:0] fill_chk_out,
	// diagnostic requests
	input wire cpu_diag_in,
	input wire [3:0] cpu_asi_in,
	input wire [19:0] cpu_addr_in,
	input wire dbg_diag_in,
	input wire [22:0] dbg_addr_in,
	input wire diag_wr_in,
	input wire [31:0] diag_wdata_in,
	// array answers
	input wire [31:0] arr_word_in,
	input wire [3:0] arr_chk_in,
	input wire [7:0] arr_ctx_in,
	input wire [31:0] rf_chk_in,
	// diagnostic outputs
	output reg [4:0] diag_sel_out,
	output reg [19:0] diag_addr_out,
	output reg diag_we_out,
	output reg [31:0] diag_wword_out,
	output reg [3:0] diag_wchk_out,
	output reg [31:0] diag_rdata_out,
	output reg diag_rvalid_out,
	// line invalidation
	output reg iinval_out,
	output reg [IDX_W-1:0] iinval_index_out,
	output reg dinval_out,
	output reg [IDX_W-1:0] dinval_index_out,
	output reg restart_out,
	// cache steering
	output reg snoop_en_out,
	output reg burst_fill_out,
	output reg [1:0] icache_state_out,
	output reg [1:0] dcache_state_out
);
	// ****************************************
	// state
	// ****************************************
	reg regfile_check_readout_r;
	reg parity_select_r;
	reg [3:0] check_xor_pattern_r;
	reg dcache_snoop_en_r;
	reg instr_burst_fill_r;
	reg dcache_freeze_on_irq_r;
	reg icache_freeze_on_irq_r;
	reg [3:0] dbg_asi_r;
	reg [1:0] cache_en_r;
	reg ifrozen_r;
	reg dfrozen_r;
	reg icache_flush_pending_r;
	reg dcache_flush_pending_r;
	reg [IDX_W-1:0] iwalk_r;
	reg [IDX_W-1:0] dwalk_r;
	reg [7:0] err_cnt_r;
	reg rd_pend_r;
	reg [2:0] rd_kind_r;
	reg rd_parsel_r;

	wire ctrl_wr;
	wire cena_wr;
	wire [3:0] err_ev;
	wire [3:0] fill_chk;
	wire [3:0] diag_chk;
	wire [1:0] icache_state;
	wire [1:0] dcache_state;
	wire [31:0] ctrl_word;
	wire [IDX_W-1:0] last_line;
	wire [7:0] err_cnt_nxt;

	assign ctrl_wr = reg_wr_in && (reg_addr_in == `CFTCD_OFF_CTRL);
	assign cena_wr = reg_wr_in && (reg_addr_in == `CFTCD_OFF_CENA);
	assign err_ev = {err_dword_in, err_dtag_in, err_iword_in, err_itag_in};
	assign last_line = LINES[IDX_W-1:0] - {{(IDX_W-1){1'b0}}, 1'b1};

	// ****************************************
	// check bit generators
	// ****************************************
	cftcd_chkgen u_fill_chk (
		.word_in(fill_data_in),
		.chk_out(fill_chk)
	);
	cftcd_chkgen u_diag_chk (
		.word_in(diag_wdata_in),
		.chk_out(diag_chk)
	);

	// ****************************************
	// cache states
	// ****************************************
	// frozen only means something while the cache is enabled
	assign icache_state = !cache_en_r[0] ? `CFTCD_ST_OFF : (ifrozen_r ? `CFTCD_ST_FROZEN : `CFTCD_ST_ON); // RQ15
	assign dcache_state = !cache_en_r[1] ? `CFTCD_ST_OFF : (dfrozen_r ? `CFTCD_ST_FROZEN : `CFTCD_ST_ON); // RQ14

	// flush bits read as zero, reserved bits zero
	assign ctrl_word = {2'h0, regfile_check_readout_r, parity_select_r, check_xor_pattern_r,
		dcache_snoop_en_r, 1'b0, 1'b0, PROT_SCHEME[1:0], 2'h0, instr_burst_fill_r, // RQ5 RQ6 RQ7
		icache_flush_pending_r, dcache_flush_pending_r, err_cnt_r, // RQ9 RQ10 RQ11
		dcache_freeze_on_irq_r, icache_freeze_on_irq_r, dcache_state, icache_state};

	// ****************************************
	// control word, freeze on interrupt, counters
	// ****************************************
	// an interrupt in the thaw cycle wins, so no freeze is lost
	always @(posedge clk_in) begin
		if (rst_in) begin
			regfile_check_readout_r <= 1'b0;
			parity_select_r <= 1'b0;
			check_xor_pattern_r <= 4'h0;
			dcache_snoop_en_r <= 1'b0;
			instr_burst_fill_r <= 1'b0;
			dcache_freeze_on_irq_r <= 1'b0;
			icache_freeze_on_irq_r <= 1'b0;
			dbg_asi_r <= `CFTCD_RST_ASI;
			cache_en_r <= `CFTCD_RST_CENA;
			ifrozen_r <= 1'b0;
			dfrozen_r <= 1'b0;
			err_cnt_r <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				regfile_check_readout_r <= reg_wdata_in[`CFTCD_RF_READOUT];
				parity_select_r <= reg_wdata_in[`CFTCD_PAR_SEL];
				check_xor_pattern_r <= reg_wdata_in[`CFTCD_XPAT_HI:`CFTCD_XPAT_LO];
				dcache_snoop_en_r <= reg_wdata_in[`CFTCD_SNOOP];
				instr_burst_fill_r <= reg_wdata_in[`CFTCD_BURST];
				dcache_freeze_on_irq_r <= reg_wdata_in[`CFTCD_DFREEZE];
				icache_freeze_on_irq_r <= reg_wdata_in[`CFTCD_IFREEZE];
			end
			if (reg_wr_in && (reg_addr_in == `CFTCD_OFF_DASI)) begin
				dbg_asi_r <= reg_wdata_in[3:0];
			end
			if (cena_wr) begin
				cache_en_r <= {reg_wdata_in[`CFTCD_EN_D], reg_wdata_in[`CFTCD_EN_I]};
			end
			if (irq_taken_in && icache_freeze_on_irq_r) begin
				ifrozen_r <= 1'b1; // RQ13
			end else if (cena_wr && reg_wdata_in[`CFTCD_THAW_I]) begin
				ifrozen_r <= 1'b0;
			end
			if (irq_taken_in && dcache_freeze_on_irq_r) begin
				dfrozen_r <= 1'b1; // RQ12
			end else if (cena_wr && reg_wdata_in[`CFTCD_THAW_D]) begin
				dfrozen_r <= 1'b0;
			end
			err_cnt_r <= err_cnt_nxt; // RQ11 RQ21
		end
	end

	// ****************************************
	// flush walkers, invalidation and restart
	// ****************************************
	// a flush request during a running flush restarts the walk from line zero
	// an error line takes the port first; the walk waits one cycle
	always @(posedge clk_in) begin
		if (rst_in) begin
			icache_flush_pending_r <= 1'b0;
			dcache_flush_pending_r <= 1'b0;
			iwalk_r <= {IDX_W{1'b0}};
			dwalk_r <= {IDX_W{1'b0}};
			iinval_out <= 1'b0;
			iinval_index_out <= {IDX_W{1'b0}};
			dinval_out <= 1'b0;
			dinval_index_out <= {IDX_W{1'b0}};
			restart_out <= 1'b0;
		end else begin
			if (ctrl_wr && reg_wdata_in[`CFTCD_IFLUSH]) begin
				icache_flush_pending_r <= 1'b1; // RQ6 RQ9
				iwalk_r <= {IDX_W{1'b0}};
			end else if (icache_flush_pending_r && !(err_itag_in || err_iword_in)) begin
				iwalk_r <= iwalk_r + {{(IDX_W-1){1'b0}}, 1'b1};
				if (iwalk_r == last_line) begin
					icache_flush_pending_r <= 1'b0; // RQ22
				end
			end
			if (ctrl_wr && reg_wdata_in[`CFTCD_DFLUSH]) begin
				dcache_flush_pending_r <= 1'b1; // RQ5 RQ10
				dwalk_r <= {IDX_W{1'b0}};
			end else if (dcache_flush_pending_r && !(err_dtag_in || err_dword_in)) begin
				dwalk_r <= dwalk_r + {{(IDX_W-1){1'b0}}, 1'b1};
				if (dwalk_r == last_line) begin
					dcache_flush_pending_r <= 1'b0; // RQ22
				end
			end
			iinval_out <= err_itag_in || err_iword_in || icache_flush_pending_r; // RQ20 RQ22
			iinval_index_out <= (err_itag_in || err_iword_in) ? err_index_in : iwalk_r;
			dinval_out <= err_dtag_in || err_dword_in || dcache_flush_pending_r; // RQ20 RQ22
			dinval_index_out <= (err_dtag_in || err_dword_in) ? err_index_in : dwalk_r;
			restart_out <= |err_ev; // RQ20
		end
	end

	// ****************************************
	// error counters
	// ****************************************
	// an error in the write cycle counts on top of the written value
	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : g_cnt
			wire [1:0] base;
			assign base = ctrl_wr ? reg_wdata_in[`CFTCD_DWORD_CNT_LO+2*(3-c)+1:`CFTCD_DWORD_CNT_LO+2*(3-c)] // RQ23
				: err_cnt_r[2*(3-c)+1:2*(3-c)];
			assign err_cnt_nxt[2*(3-c)+1:2*(3-c)] = (err_ev[c] && base != `CFTCD_CNT_MAX) ? // RQ11 RQ21
				base + 2'h1 : base;
		end
	endgenerate

	// ****************************************
	// diagnostic request stage
	// ****************************************
	reg [3:0] req_asi;
	reg [19:0] req_addr;
	reg req_ok;
	reg [4:0] req_sel;
	always @* begin
		req_asi = cpu_asi_in;
		req_addr = cpu_addr_in;
		req_ok = cpu_diag_in;
		req_sel = 5'h00;
		// debug accesses outside the window are not for this block
		if (dbg_diag_in && dbg_addr_in[22:20] == `CFTCD_WIN_BASE) begin
			req_asi = dbg_asi_r; // RQ19
			req_addr = dbg_addr_in[19:0]; // RQ19
			req_ok = 1'b1;
		end
		if (req_ok) begin
			case (req_asi)
				`CFTCD_ASI_ITAG: req_sel = 5'h01; // RQ19
				`CFTCD_ASI_IWORD: req_sel = 5'h02; // RQ19
				`CFTCD_ASI_DTAG: req_sel = 5'h04; // RQ19
				`CFTCD_ASI_DWORD: begin
					// register file readout only for reads
					req_sel = (regfile_check_readout_r && !diag_wr_in) ? 5'h10 : 5'h08; // RQ1
				end
				default: req_sel = 5'h00;
			endcase
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			diag_sel_out <= 5'h00;
			diag_addr_out <= 20'h00000;
			diag_we_out <= 1'b0;
			diag_wword_out <= 32'h00000000;
			diag_wchk_out <= 4'h0;
			fill_chk_out <= 4'h0;
			rd_pend_r <= 1'b0;
			rd_kind_r <= 3'h0;
			rd_parsel_r <= 1'b0;
		end else begin
			diag_sel_out <= req_sel;
			diag_addr_out <= req_addr;
			diag_we_out <= diag_wr_in && (req_sel != 5'h00);
			diag_wword_out <= diag_wdata_in;
			// pattern zero leaves the generated bits untouched
			diag_wchk_out <= diag_chk ^ check_xor_pattern_r; // RQ3
			if (fill_in) begin
				fill_chk_out <= fill_chk; // RQ18
			end
			rd_pend_r <= !diag_wr_in && (req_sel != 5'h00);
			rd_kind_r <= req_sel[4] ? 3'h4 : ((req_sel[0] || req_sel[2]) ? 3'h1 : 3'h2);
			rd_parsel_r <= parity_select_r;
		end
	end

	// ****************************************
	// diagnostic read answer
	// ****************************************
	always @(posedge clk_in) begin
		if (rst_in) begin
			diag_rdata_out <= 32'h00000000;
			diag_rvalid_out <= 1'b0;
		end else begin
			diag_rvalid_out <= rd_pend_r;
			if (rd_pend_r) begin
				if (rd_kind_r[2]) begin
					diag_rdata_out <= rf_chk_in; // RQ1
				end else if (!rd_parsel_r) begin
					diag_rdata_out <= arr_word_in; // RQ2
				end else if (rd_kind_r[0]) begin
					diag_rdata_out <= {8'h00, arr_ctx_in, 12'h000, arr_chk_in}; // RQ16 RQ17
				end else begin
					diag_rdata_out <= {28'h0000000, arr_chk_in}; // RQ2 RQ17
				end
			end
		end
	end

	// ****************************************
	// register read and steering outputs
	// ****************************************
	always @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h00000000;
			snoop_en_out <= 1'b0;
			burst_fill_out <= 1'b0;
			icache_state_out <= `CFTCD_ST_OFF;
			dcache_state_out <= `CFTCD_ST_OFF;
		end else begin
			reg_rdata_out <= 32'h00000000;
			if (reg_rd_in) begin
				case (reg_addr_in)
					`CFTCD_OFF_CTRL: reg_rdata_out <= ctrl_word;
					`CFTCD_OFF_DASI: reg_rdata_out <= {28'h0000000, dbg_asi_r};
					`CFTCD_OFF_CENA: reg_rdata_out <= {30'h00000000, cache_en_r};
					default: reg_rdata_out <= 32'h00000000;
				endcase
			end
			snoop_en_out <= dcache_snoop_en_r; // RQ4
			burst_fill_out <= instr_burst_fill_r; // RQ8
			icache_state_out <= icache_state; // RQ15
			dcache_state_out <= dcache_state; // RQ14
		end
	end
endmodule

// *** verif/cftcd_ctrl_sva.sv ***
// Purpose: port checker for cftcd_ctrl
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance at the foot
`timescale 1ns/10ps
module cftcd_ctrl_sva #(
	parameter IDX_W = 7
) (
	input wire clk_in,
	input wire rst_in,
	input wire [3:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [31:0] reg_rdata_out,
	input wire err_itag_in,
	input wire err_dword_in,
	input wire [IDX_W-1:0] err_index_in,
	input wire fill_in,
	input wire [31:0] fill_data_in,
	input wire [3:0] fill_chk_out,
	input wire cpu_diag_in,
	input wire [3:0] cpu_asi_in,
	input wire dbg_diag_in,
	input wire diag_wr_in,
	input wire [4:0] diag_sel_out,
	input wire diag_we_out,
	input wire diag_rvalid_out,
	input wire iinval_out,
	input wire [IDX_W-1:0] iinval_index_out,
	input wire dinval_out,
	input wire [IDX_W-1:0] dinval_index_out,
	input wire restart_out
);
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (rst_in);
	reg [31:0] fill_q;
	always @(posedge clk_in) begin
		fill_q <= fill_data_in;
	end
	// ****
	// port relations
	// ****
	a_flush_reads_zero: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[22:21] == 2'h0)
		else $error("flush bit read back nonzero");
	a_scheme_code: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[20:19] == 2'h1)
		else $error("scheme field wrong");
	a_iflush_walk: assert property (reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[21] |->
		##2 iinval_out && iinval_index_out == 0 ##1 iinval_out && iinval_index_out == 1)
		else $error("icache walk did not start at line 0");
	a_dflush_walk: assert property (reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[22] |->
		##2 dinval_out && dinval_index_out == 0 ##1 dinval_out [*2])
		else $error("dcache walk did not start at line 0");
	a_err_restart: assert property (err_itag_in || err_dword_in |=> restart_out)
		else $error("no restart after check error");
	a_err_line_inval: assert property (err_dword_in |=> dinval_out && dinval_index_out == $past(err_index_in))
		else $error("failing line not invalidated");
	a_fill_check: assert property (fill_in |=>
		fill_chk_out == {^fill_q[31:24], ^fill_q[23:16], ^fill_q[15:8], ^fill_q[7:0]})
		else $error("fill check bits wrong");
	a_diag_write: assert property (cpu_diag_in && diag_wr_in && !dbg_diag_in && cpu_asi_in == 4'hD |=>
		diag_we_out && diag_sel_out == 5'h02)
		else $error("diagnostic write not steered");
	a_diag_read: assert property (cpu_diag_in && !diag_wr_in && !dbg_diag_in && cpu_asi_in[3:2] == 2'h3 |=>
		!diag_we_out ##1 diag_rvalid_out)
		else $error("diagnostic read gave no data");
	a_bad_space: assert property (cpu_diag_in && !dbg_diag_in && cpu_asi_in[3:2] != 2'h3 |=>
		diag_sel_out == 5'h0 ##1 !diag_rvalid_out)
		else $error("foreign space reached the arrays");
endmodule
bind cftcd_ctrl cftcd_ctrl_sva #(.IDX_W(IDX_W)) chk_u (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .err_itag_in, .err_dword_in, .err_index_in, .fill_in, .fill_data_in, .fill_chk_out,
	.cpu_diag_in, .cpu_asi_in, .dbg_diag_in, .diag_wr_in, .diag_sel_out, .diag_we_out, .diag_rvalid_out, .iinval_out,
	.iinval_index_out, .dinval_out, .dinval_index_out, .restart_out);

// *** verif/testbench.sv ***
// Purpose: self-checking bench for cftcd_ctrl
// Assumes: 50 MHz clock, eight lines to keep flushes short
// Notes: bench model holds the writable control bits
`timescale 1ns/10ps
module testbench;
	localparam LN = 8;
	localparam MSK = 32'h3F813FF0;
	logic clk_in, rst_in, reg_wr_in, reg_rd_in, irq_taken_in, fill_in, cpu_diag_in, dbg_diag_in, diag_wr_in;
	logic err_itag_in, err_iword_in, err_dtag_in, err_dword_in, diag_we_out, diag_rvalid_out, rv_q;
	logic iinval_out, dinval_out, restart_out, snoop_en_out, burst_fill_out;
	logic [1:0] icache_state_out, dcache_state_out;
	logic [2:0] err_index_in, iinval_index_out, dinval_index_out;
	logic [3:0] reg_addr_in, cpu_asi_in, arr_chk_in, fill_chk_out, diag_wchk_out, wchk_q;
	logic [4:0] diag_sel_out, sel_q;
	logic [7:0] arr_ctx_in;
	logic [19:0] cpu_addr_in, diag_addr_out, addr_q, a_q;
	logic [22:0] dbg_addr_in;
	logic [31:0] reg_wdata_in, fill_data_in, diag_wdata_in, arr_word_in, rf_chk_in, reg_rdata_out;
	logic [31:0] diag_wword_out, diag_rdata_out, m_ctrl, q, e, ww_q;
	integer failures, n_checks, seed, n_iinv, n_dinv, k;
	cftcd_ctrl #(.IDX_W(3), .LINES(LN)) dut_u (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .irq_taken_in, .err_itag_in, .err_iword_in, .err_dtag_in, .err_dword_in, .err_index_in,
		.fill_in, .fill_data_in, .fill_chk_out, .cpu_diag_in, .cpu_asi_in, .cpu_addr_in, .dbg_diag_in, .dbg_addr_in,
		.diag_wr_in, .diag_wdata_in, .arr_word_in, .arr_chk_in, .arr_ctx_in, .rf_chk_in, .diag_sel_out, .diag_addr_out,
		.diag_we_out, .diag_wword_out, .diag_wchk_out, .diag_rdata_out, .diag_rvalid_out, .iinval_out,
		.iinval_index_out, .dinval_out, .dinval_index_out, .restart_out, .snoop_en_out, .burst_fill_out,
		.icache_state_out, .dcache_state_out);
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// line counts only; index order is left to the checker
	always @(posedge clk_in) begin
		if (iinval_out) n_iinv <= n_iinv + 1;
		if (dinval_out) n_dinv <= n_dinv + 1;
	end
	function [3:0] par(input [31:0] v);
		par = {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]};
	endfunction
	task chk(input string nm, input [31:0] ex, input [31:0] g);
		n_checks = n_checks + 1;
		if (g !== ex) begin
			failures = failures + 1;
			$display("ERROR %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task wr(input [3:0] a, input [31:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		if (a == 4'h0) m_ctrl = d & MSK;
	endtask
	task rd(input [3:0] a);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 q = reg_rdata_out;
	endtask
	task rd_ctrl(input [31:0] st);
		rd(4'h0);
		chk("ctrl", m_ctrl | 32'h00080000 | st, q);
	endtask
	task st_chk(input [1:0] d, input [1:0] i);
		chk("dcache_state", 32'(d), 32'(dcache_state_out));
		chk("icache_state", 32'(i), 32'(icache_state_out));
	endtask
	// one-cycle events: irq, fill, itag, iword, dtag, dword
	task ev(input [5:0] m);
		@(posedge clk_in);
		{irq_taken_in, fill_in, err_itag_in, err_iword_in, err_dtag_in, err_dword_in} <= m;
		err_index_in <= $random(seed);
		fill_data_in <= $random(seed);
		@(posedge clk_in);
		{irq_taken_in, fill_in, err_itag_in, err_iword_in, err_dtag_in, err_dword_in} <= 6'h0;
	endtask
	task diag(input d, input [3:0] s, input w);
		@(posedge clk_in);
		a_q = $random(seed);
		cpu_diag_in <= !d;
		dbg_diag_in <= d;
		cpu_asi_in <= s;
		cpu_addr_in <= a_q;
		dbg_addr_in <= {3'h7, a_q};
		diag_wr_in <= w;
		diag_wdata_in <= $random(seed);
		arr_word_in <= $random(seed);
		arr_chk_in <= $random(seed);
		arr_ctx_in <= $random(seed);
		rf_chk_in <= $random(seed);
		@(posedge clk_in);
		cpu_diag_in <= 1'b0;
		dbg_diag_in <= 1'b0;
		#1 sel_q = diag_sel_out;
		wchk_q = diag_wchk_out;
		addr_q = diag_addr_out;
		ww_q = diag_wword_out;
		@(posedge clk_in);
		#1 rv_q = diag_rvalid_out;
		q = diag_rdata_out;
	endtask
	initial begin
		#200000;
		failures = failures + 1;
		conclude;
	end
	// ****
	// tests
	// ****
	initial begin
		{failures, n_checks, n_iinv, n_dinv, m_ctrl} = 160'h0;
		seed = 32'hBF99;
		{reg_wr_in, reg_rd_in, irq_taken_in, fill_in, cpu_diag_in, dbg_diag_in, diag_wr_in} = 7'h0;
		{err_itag_in, err_iword_in, err_dtag_in, err_dword_in} = 4'h0;
		{reg_addr_in, cpu_asi_in, arr_chk_in, err_index_in, arr_ctx_in, cpu_addr_in, dbg_addr_in} = 66'h0;
		{reg_wdata_in, fill_data_in, diag_wdata_in, arr_word_in, rf_chk_in} = 160'h0;
		rst_in = 1'b1;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		rd_ctrl(32'h0);
		rd(4'h4);
		chk("space_reg", 32'h0, q);
		rd(4'hC);
		chk("unmapped", 32'h0, q);
		st_chk(2'h0, 2'h0);
		$display("test reset done");
		for (k = 0; k < 6; k++) begin
			wr(4'h0, $random(seed) & 32'hFF9FFFFF);
			rd_ctrl(32'h0);
			chk("snoop", 32'(m_ctrl[23]), 32'(snoop_en_out));
			chk("burst", 32'(m_ctrl[16]), 32'(burst_fill_out));
		end
		$display("test control word done");
		wr(4'h0, 32'h0);
		for (k = 0; k < 4; k++) ev({2'h0, 1'b1, k < 1, k < 2, k < 3});
		m_ctrl = 32'h000036C0;
		rd_ctrl(32'h0);
		wr(4'h0, 32'h0);
		rd_ctrl(32'h0);
		$display("test counters done");
		for (k = 0; k < 2; k++) begin
			n_iinv = 0;
			n_dinv = 0;
			wr(4'h0, 32'h00200000 << k);
			rd_ctrl(32'h00008000 >> k);
			repeat (LN + 2) @(posedge clk_in);
			chk("inval_count", LN, k ? n_dinv : n_iinv);
			chk("other_inval", 0, k ? n_iinv : n_dinv);
			rd_ctrl(32'h0);
		end
		$display("test flush done");
		wr(4'h8, 32'h3);
		wr(4'h0, 32'h20);
		ev(6'h20);
		rd_ctrl(32'h7);
		st_chk(2'h1, 2'h3);
		wr(4'h8, 32'hB);
		wr(4'h0, 32'h10);
		ev(6'h20);
		rd_ctrl(32'hD);
		st_chk(2'h3, 2'h1);
		wr(4'h8, 32'h0);
		rd_ctrl(32'h0);
		st_chk(2'h0, 2'h0);
		ev(6'h10);
		#1 chk("fill_check", 32'(par(fill_data_in)), 32'(fill_chk_out));
		$display("test state done");
		for (k = 0; k < 8; k++) begin
			wr(4'h0, {3'h0, k[2], 28'h0});
			diag(1'b0, {2'h3, k[1:0]}, 1'b0);
			chk("diag_sel", 32'(5'h1 << k[1:0]), 32'(sel_q));
			e = !k[2] ? arr_word_in : k[0] ? {28'h0, arr_chk_in} : {8'h0, arr_ctx_in, 12'h0, arr_chk_in};
			chk("diag_rdata", e, q);
			chk("diag_rvalid", 1, 32'(rv_q));
		end
		wr(4'h0, 32'h20000000);
		diag(1'b0, 4'hF, 1'b0);
		chk("rf_sel", 32'h10, 32'(sel_q));
		chk("rf_rdata", rf_chk_in, q);
		wr(4'h0, 32'h0A000000);
		diag(1'b0, 4'hD, 1'b1);
		chk("wr_check", 32'(par(diag_wdata_in) ^ 4'hA), 32'(wchk_q));
		chk("wr_word", diag_wdata_in, ww_q);
		wr(4'h4, 32'hE);
		diag(1'b1, 4'h0, 1'b0);
		chk("dbg_sel", 32'h4, 32'(sel_q));
		chk("dbg_addr", 32'(a_q), 32'(addr_q));
		diag(1'b0, 4'h9, 1'b0);
		chk("bad_space", 32'h0, 32'({sel_q, rv_q}));
		$display("test diagnostic done");
		conclude;
	end
endmodule
